// *** rtl/user_io_pkg.sv ***
// Package with register map, reset values and carrier types for the user I/O ports.
package user_io_pkg;

    localparam int           PORT_W          = 8;
    localparam logic [7:0]   SFR_PORT_A_DATA = 8'h90;
    localparam logic [7:0]   SFR_PORT_A_DIR  = 8'h91;
    localparam logic [7:0]   SFR_PORT_B_DATA = 8'hd8;
    localparam logic [7:0]   SFR_PORT_B_DIR  = 8'hd9;
    localparam logic [15:0]  XD_PORT_C_DATA  = 16'h0000;
    localparam logic [15:0]  XD_PORT_C_DIR   = 16'h0001;
    localparam logic [15:0]  XD_BANK_SEL     = 16'h0002;
    localparam logic [7:0]   DATA_RESET      = 8'h00;
    localparam logic [7:0]   DIR_RESET       = 8'hff;
    localparam logic [7:0]   BANK_RESET      = 8'h00;
    localparam logic [7:0]   ISOLATED_INPUT  = 8'hff;
    localparam int           BANK_EN_BIT     = 2;
    localparam int           BANK_HI_BIT     = 1;
    localparam int           BANK_LO_BIT     = 0;
    localparam int           BANK_A16_PIN    = 7;
    localparam int           TMR0_PIN        = 0;
    localparam int           TMR1_PIN        = 1;
    localparam int           TMR2_TRIG_PIN   = 2;
    localparam int           TMR2_PIN        = 3;

    // Special-function register access from the core.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       rmw;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // External data access from the external move instruction.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xdata_req_t;

    // Per-port pin group: output value and output enable.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

endpackage

// *** rtl/io_port.sv ***
// One eight-bit port: data and direction storage, isolation after reset and the input level seen by the core.
`timescale 1ns/1ps
module io_port #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Register writes
    input  wire logic         data_we,
    input  wire logic         dir_we,
    input  wire logic [W-1:0] wdata,
    // Pin side
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] data_q,
    output logic      [W-1:0] dir_q,
    output logic              live_q,
    output logic      [W-1:0] pin_level
);
    import user_io_pkg::*;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= W'(DATA_RESET);
        end else if (data_we) begin
            data_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= W'(DIR_RESET);
        end else if (dir_we) begin
            dir_q <= wdata;
        end
    end

    // The first direction write releases the port from isolation; it never re-arms.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q <= 1'b0;
        end else if (dir_we) begin
            live_q <= 1'b1;
        end
    end

    // Isolated ports see ones so floating pads cannot leak into the core.
    assign pin_level = live_q ? pin_in : W'(ISOLATED_INPUT);

endmodule

// *** rtl/user_io_ports.sv ***
// Top of the three user I/O ports and the program bank select logic.
`timescale 1ns/1ps
// Overview of operation
// - Direction one means input, zero drives data.
// - Ports A,B on SPECIAL_FUNCTION_REGISTER bus; C external.
// - SPECIAL_FUNCTION_REGISTER data read: pins, latch for RMW.
// - External data read always returns pins.
// - Port A data 90h, direction 91h.
// - Port B data D8h, direction D9h.
// - Port C data 0000h, direction 0001h.
// - Reset: data 00h, direction FFh.
// - After reset pins float, inputs read one.
// - Isolation ends at first direction write.
// - Port A bits feed timer inputs.
// - Bank enable: C pin 7 is A16 on fetch.
// - Bank enable forces C pin 7 output.
// - Bank disabled: A15 passes, pin ordinary.
// - Bank field remaps A15 and A16.
// - Bank register at 0002h, reset 00h.
// - Bank bits 7:3 are spare storage.
module user_io_ports #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    // Special-function register bus
    input  wire user_io_pkg::sfr_req_t   SFR_REQ,
    output logic [7:0]                   SFR_RDATA,
    output logic                         SFR_HIT,
    // External data bus
    input  wire user_io_pkg::xdata_req_t XD_REQ,
    output logic [7:0]                   XD_RDATA,
    output logic                         XD_HIT,
    // Program address banking
    input  wire logic                    FETCH,
    input  wire logic                    CORE_ADDRESS_MSB,
    output logic                         A15_OUT,
    // Port pins
    input  wire logic [W-1:0]            PORT_A_IN,
    output user_io_pkg::pin_drive_t      PORT_A_PIN,
    input  wire logic [W-1:0]            PORT_B_IN,
    output user_io_pkg::pin_drive_t      PORT_B_PIN,
    input  wire logic [W-1:0]            PORT_C_IN,
    output user_io_pkg::pin_drive_t      PORT_C_PIN,
    // Timer inputs
    output logic                         TIMER0_COUNT_INPUT,
    output logic                         TIMER1_COUNT_INPUT,
    output logic                         TIMER2_TRIGGER_INPUT,
    output logic                         TIMER2_COUNT_INPUT
);
    import user_io_pkg::*;

    logic [W-1:0] a_data, a_dir, a_lvl;
    logic [W-1:0] b_data, b_dir, b_lvl;
    logic [W-1:0] c_data, c_dir, c_lvl;
    logic         a_live, b_live, c_live;
    logic [7:0]   bank_ff;
    logic         a_dat_we, a_dir_we, b_dat_we, b_dir_we;
    logic         c_dat_we, c_dir_we, bank_we;
    logic         nxt_a15, nxt_a16, bank_on;
    logic [7:0]   nxt_sfr_rdata, nxt_xd_rdata;
    logic         nxt_sfr_hit, nxt_xd_hit;
    logic [W-1:0] nxt_a_oe, nxt_b_oe, nxt_c_oe, nxt_c_out;

    // Write strobe for one internal-bus register.
    function automatic logic sfr_write_to(input sfr_req_t req, input logic [7:0] addr);
        sfr_write_to = req.wr && (req.addr == addr);
    endfunction

    // Write strobe for one external data register.
    function automatic logic xd_write_to(input xdata_req_t req, input logic [15:0] addr);
        xd_write_to = req.wr && (req.addr == addr);
    endfunction

    // Internal-bus address that names one of the four port registers.
    function automatic logic sfr_mapped(input logic [7:0] addr);
        sfr_mapped = (addr == SFR_PORT_A_DATA) || (addr == SFR_PORT_A_DIR)
                     || (addr == SFR_PORT_B_DATA) || (addr == SFR_PORT_B_DIR);
    endfunction

    // External address that names a register of this block.
    function automatic logic xd_mapped(input logic [15:0] addr);
        xd_mapped = (addr == XD_PORT_C_DATA) || (addr == XD_PORT_C_DIR)
                    || (addr == XD_BANK_SEL);
    endfunction

    // Data register read on the internal bus: the latch for modify reads, else the pins.
    function automatic logic [7:0] port_read(input logic rmw, input logic [W-1:0] latch,
                                             input logic [W-1:0] pins);
        port_read = 8'(rmw ? latch : pins);
    endfunction

    // Pin enables: a port still isolated after reset drives nothing.
    function automatic logic [W-1:0] pin_enable(input logic live, input logic [W-1:0] dir);
        pin_enable = live ? ~dir : '0;
    endfunction

    // Remapped A15; only enabled fetches from the upper half are moved.
    function automatic logic bank_a15(input logic [7:0] sel, input logic fetch,
                                      input logic msb);
        bank_a15 = msb;
        if (sel[BANK_EN_BIT] && fetch && msb) begin
            bank_a15 = ~sel[BANK_LO_BIT];
        end
    endfunction

    // A16 for the pin; zero for data cycles and for the lower half.
    function automatic logic bank_a16(input logic [7:0] sel, input logic fetch,
                                      input logic msb);
        bank_a16 = 1'b0;
        if (sel[BANK_EN_BIT] && fetch && msb) begin
            bank_a16 = sel[BANK_HI_BIT] | sel[BANK_LO_BIT];
        end
    endfunction

    // Register write decode on both buses.
    assign a_dat_we = sfr_write_to(SFR_REQ, SFR_PORT_A_DATA);
    assign a_dir_we = sfr_write_to(SFR_REQ, SFR_PORT_A_DIR);
    assign b_dat_we = sfr_write_to(SFR_REQ, SFR_PORT_B_DATA);
    assign b_dir_we = sfr_write_to(SFR_REQ, SFR_PORT_B_DIR);
    assign c_dat_we = xd_write_to(XD_REQ, XD_PORT_C_DATA);
    assign c_dir_we = xd_write_to(XD_REQ, XD_PORT_C_DIR);
    assign bank_we  = xd_write_to(XD_REQ, XD_BANK_SEL);

    io_port #(.W(W)) u_port_a (
        .clk       (CLK),
        .rst_n     (RST_N),
        .data_we   (a_dat_we),
        .dir_we    (a_dir_we),
        .wdata     (SFR_REQ.wdata[W-1:0]),
        .pin_in    (PORT_A_IN),
        .data_q    (a_data),
        .dir_q     (a_dir),
        .live_q    (a_live),
        .pin_level (a_lvl)
    );

    io_port #(.W(W)) u_port_b (
        .clk       (CLK),
        .rst_n     (RST_N),
        .data_we   (b_dat_we),
        .dir_we    (b_dir_we),
        .wdata     (SFR_REQ.wdata[W-1:0]),
        .pin_in    (PORT_B_IN),
        .data_q    (b_data),
        .dir_q     (b_dir),
        .live_q    (b_live),
        .pin_level (b_lvl)
    );

    io_port #(.W(W)) u_port_c (
        .clk       (CLK),
        .rst_n     (RST_N),
        .data_we   (c_dat_we),
        .dir_we    (c_dir_we),
        .wdata     (XD_REQ.wdata[W-1:0]),
        .pin_in    (PORT_C_IN),
        .data_q    (c_data),
        .dir_q     (c_dir),
        .live_q    (c_live),
        .pin_level (c_lvl)
    );

    // Spare bits are plain storage, read back unchanged.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bank_ff <= BANK_RESET;
        end else if (bank_we) begin
            bank_ff <= XD_REQ.wdata;
        end
    end

    assign bank_on = bank_ff[BANK_EN_BIT];

    // Fetch remap: A15 stays low for the lower half; the bank field decides only for enabled upper-half fetches, other cycles pass A15.
    always_comb begin
        nxt_a15 = bank_a15(bank_ff, FETCH, CORE_ADDRESS_MSB);
        nxt_a16 = bank_a16(bank_ff, FETCH, CORE_ADDRESS_MSB);
    end

    // Bank outputs are registered, so the core presents the fetch qualifier
    // one cycle ahead of the external address phase.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            A15_OUT <= 1'b0;
        end else begin
            A15_OUT <= nxt_a15;
        end
    end

    // Pin 7 of port C is claimed by banking even before the first direction write,
    // so the program memory sees A16 as soon as banking is switched on.
    always_comb begin
        nxt_a_oe  = pin_enable(a_live, a_dir);
        nxt_b_oe  = pin_enable(b_live, b_dir);
        nxt_c_oe  = pin_enable(c_live, c_dir);
        nxt_c_out = c_data;
        if (bank_on) begin
            nxt_c_out[BANK_A16_PIN] = nxt_a16;
            nxt_c_oe[BANK_A16_PIN]  = 1'b1;
        end
    end

    // Port A pins.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_A_PIN <= '0;
        end else begin
            PORT_A_PIN.out <= a_data;
            PORT_A_PIN.oe  <= nxt_a_oe;
        end
    end

    // Port B pins.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_B_PIN <= '0;
        end else begin
            PORT_B_PIN.out <= b_data;
            PORT_B_PIN.oe  <= nxt_b_oe;
        end
    end

    // Port C pins, with the bank override on pin 7.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_C_PIN <= '0;
        end else begin
            PORT_C_PIN.out <= nxt_c_out;
            PORT_C_PIN.oe  <= nxt_c_oe;
        end
    end

    // Each timer input has its own register, so one can be retimed on its own.
    // Timer 0 count follows port A pin 0; an isolated port gives one.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER0_COUNT_INPUT <= 1'b1;
        end else begin
            TIMER0_COUNT_INPUT <= a_lvl[TMR0_PIN];
        end
    end

    // Timer 1 count follows port A pin 1.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER1_COUNT_INPUT <= 1'b1;
        end else begin
            TIMER1_COUNT_INPUT <= a_lvl[TMR1_PIN];
        end
    end

    // Timer 2 trigger follows port A pin 2.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER2_TRIGGER_INPUT <= 1'b1;
        end else begin
            TIMER2_TRIGGER_INPUT <= a_lvl[TMR2_TRIG_PIN];
        end
    end

    // Timer 2 count follows port A pin 3.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER2_COUNT_INPUT <= 1'b1;
        end else begin
            TIMER2_COUNT_INPUT <= a_lvl[TMR2_PIN];
        end
    end

    // Special-function read map; an unmapped address reads zero with no hit.
    always_comb begin
        nxt_sfr_rdata = 8'h00;
        nxt_sfr_hit   = SFR_REQ.rd && sfr_mapped(SFR_REQ.addr);
        if (SFR_REQ.rd) begin
            unique case (SFR_REQ.addr)
                SFR_PORT_A_DATA: nxt_sfr_rdata = port_read(SFR_REQ.rmw, a_data, a_lvl);
                SFR_PORT_A_DIR:  nxt_sfr_rdata = 8'(a_dir);
                SFR_PORT_B_DATA: nxt_sfr_rdata = port_read(SFR_REQ.rmw, b_data, b_lvl);
                SFR_PORT_B_DIR:  nxt_sfr_rdata = 8'(b_dir);
                default:         nxt_sfr_rdata = 8'h00;
            endcase
        end
    end

    // Special-function read data stands for one cycle after the request.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SFR_RDATA <= 8'h00;
        end else begin
            SFR_RDATA <= nxt_sfr_rdata;
        end
    end

    // The hit flag marks the cycle in which the read data stands.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SFR_HIT <= 1'b0;
        end else begin
            SFR_HIT <= nxt_sfr_hit;
        end
    end

    // External read map; the data register always shows the pins.
    always_comb begin
        nxt_xd_rdata = 8'h00;
        nxt_xd_hit   = XD_REQ.rd && xd_mapped(XD_REQ.addr);
        if (XD_REQ.rd) begin
            unique case (XD_REQ.addr)
                XD_PORT_C_DATA: nxt_xd_rdata = 8'(c_lvl);
                XD_PORT_C_DIR:  nxt_xd_rdata = 8'(c_dir);
                XD_BANK_SEL:    nxt_xd_rdata = bank_ff;
                default:        nxt_xd_rdata = 8'h00;
            endcase
        end
    end

    // External read data stands for one cycle after the request.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            XD_RDATA <= 8'h00;
        end else begin
            XD_RDATA <= nxt_xd_rdata;
        end
    end

    // The external hit flag marks the cycle in which the read data stands.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            XD_HIT <= 1'b0;
        end else begin
            XD_HIT <= nxt_xd_hit;
        end
    end

endmodule

// *** tb/io_pin_model.sv ***
// Board model for one port: peripherals drive the lines that the port leaves free.
`timescale 1ns/1ps
module io_pin_model (
    // Port drive and the peripherals' own levels
    input  wire user_io_pkg::pin_drive_t pins,
    input  wire logic [7:0]              ext,
    // Line levels fed back to the port
    output logic      [7:0]              level
);
    import user_io_pkg::*;
    // A driven line shows the port's value; a released line shows the peripheral's.
    assign level = (pins.out & pins.oe) | (ext & ~pins.oe);
endmodule

// *** tb/user_io_ports_asserts.sv ***
// Concurrent checks on the ports of the user I/O and bank select block.
`timescale 1ns/1ps
module user_io_ports_asserts #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic                    CLK,
    input wire logic                    RST_N,
    // Register buses
    input wire user_io_pkg::sfr_req_t   SFR_REQ,
    input wire logic [7:0]              SFR_RDATA,
    input wire logic                    SFR_HIT,
    input wire user_io_pkg::xdata_req_t XD_REQ,
    input wire logic                    XD_HIT,
    // Banking and pins
    input wire logic                    FETCH,
    input wire logic                    CORE_ADDRESS_MSB,
    input wire logic                    A15_OUT,
    input wire user_io_pkg::pin_drive_t PORT_A_PIN,
    input wire user_io_pkg::pin_drive_t PORT_C_PIN,
    input wire logic                    TIMER0_COUNT_INPUT
);
    import user_io_pkg::*;
    logic       a_live_ff;
    logic       c_live_ff;
    logic [7:0] a_data_ff;
    logic [7:0] bank_ff;
    logic       sfr_ok;
    assign sfr_ok = SFR_REQ.addr inside {8'h90, 8'h91, 8'hd8, 8'hd9};
    // Shadow copies let the checks see the register state without the bodies.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            a_live_ff <= 1'b0;
            c_live_ff <= 1'b0;
            a_data_ff <= 8'h00;
            bank_ff   <= 8'h00;
        end else begin
            if (SFR_REQ.wr && SFR_REQ.addr == SFR_PORT_A_DIR) a_live_ff <= 1'b1;
            if (SFR_REQ.wr && SFR_REQ.addr == SFR_PORT_A_DATA) a_data_ff <= SFR_REQ.wdata;
            if (XD_REQ.wr && XD_REQ.addr == XD_PORT_C_DIR) c_live_ff <= 1'b1;
            if (XD_REQ.wr && XD_REQ.addr == XD_BANK_SEL) bank_ff <= XD_REQ.wdata;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sfr_hit_a: assert property (SFR_REQ.rd && sfr_ok |=> SFR_HIT)
        else $error("mapped read gave no hit");
    sfr_miss_a: assert property (SFR_REQ.rd && !sfr_ok |=> !SFR_HIT && SFR_RDATA == 8'h00)
        else $error("unmapped read answered");
    xd_hit_a: assert property (XD_REQ.rd && XD_REQ.addr <= 16'h0002 |=> XD_HIT)
        else $error("external read gave no hit");
    rmw_latch_a: assert property (SFR_REQ.rd && SFR_REQ.rmw && !SFR_REQ.wr
        && SFR_REQ.addr == SFR_PORT_A_DATA |=> SFR_RDATA == a_data_ff)
        else $error("modify read did not return latch");
    a_isolate_a: assert property (!a_live_ff |-> PORT_A_PIN.oe == 8'h00 && TIMER0_COUNT_INPUT)
        else $error("port a left isolation early");
    c_isolate_a: assert property (!c_live_ff |-> PORT_C_PIN.oe[6:0] == 7'h00)
        else $error("port c left isolation early");
    a15_remap_a: assert property (##1 A15_OUT
        == $past(CORE_ADDRESS_MSB && !(FETCH && bank_ff[2] && bank_ff[0])))
        else $error("a15 output wrong");
    a16_pin_a: assert property (bank_ff[2] |=> PORT_C_PIN.oe[7]
        && PORT_C_PIN.out[7] == $past(FETCH && CORE_ADDRESS_MSB && |bank_ff[1:0]))
        else $error("a16 pin wrong");
endmodule
bind user_io_ports user_io_ports_asserts #(.W(W)) u_chk (
    .CLK(CLK), .RST_N(RST_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
    .SFR_HIT(SFR_HIT), .XD_REQ(XD_REQ), .XD_HIT(XD_HIT), .FETCH(FETCH),
    .CORE_ADDRESS_MSB(CORE_ADDRESS_MSB), .A15_OUT(A15_OUT), .PORT_A_PIN(PORT_A_PIN),
    .PORT_C_PIN(PORT_C_PIN), .TIMER0_COUNT_INPUT(TIMER0_COUNT_INPUT));

// *** tb/user_io_ports_tb.sv ***
// Self-checking bench for the user I/O ports and bank select logic.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module user_io_ports_tb;
    import user_io_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    sfr_req_t   sfr_req = '0;
    xdata_req_t xd_req = '0;
    logic       fetch = 1'b0;
    logic       msb = 1'b0;
    logic [7:0] lvl_a, lvl_b, lvl_c, sfr_rdata, xd_rdata;
    logic       sfr_hit, xd_hit, a15, t0, t1, t2x, t2;
    pin_drive_t pin_a, pin_b, pin_c;
    int         err_total = 0;
    int         n_checks = 0;
    int         cyc = 0;
    always #5 clk = ~clk;
    user_io_ports u_dut (.CLK(clk), .RST_N(rst_n), .SFR_REQ(sfr_req), .SFR_RDATA(sfr_rdata),
        .SFR_HIT(sfr_hit), .XD_REQ(xd_req), .XD_RDATA(xd_rdata), .XD_HIT(xd_hit),
        .FETCH(fetch), .CORE_ADDRESS_MSB(msb), .A15_OUT(a15), .PORT_A_IN(lvl_a),
        .PORT_A_PIN(pin_a), .PORT_B_IN(lvl_b), .PORT_B_PIN(pin_b), .PORT_C_IN(lvl_c),
        .PORT_C_PIN(pin_c), .TIMER0_COUNT_INPUT(t0), .TIMER1_COUNT_INPUT(t1),
        .TIMER2_TRIGGER_INPUT(t2x), .TIMER2_COUNT_INPUT(t2));
    io_pin_model u_pa (.pins(pin_a), .ext(8'h3c), .level(lvl_a));
    io_pin_model u_pb (.pins(pin_b), .ext(8'h99), .level(lvl_b));
    io_pin_model u_pc (.pins(pin_c), .ext(8'h24), .level(lvl_c));
    task automatic sfr_wr(input logic [7:0] a, d);
        @(posedge clk) sfr_req <= '{1'b1, 1'b0, 1'b0, a, d};
        @(posedge clk) sfr_req <= '0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, input logic m, input logic [8:0] e);
        @(posedge clk) sfr_req <= '{1'b0, 1'b1, m, a, 8'h00};
        @(posedge clk) sfr_req <= '0;
        #1 `CHK("sfr read", e, {sfr_hit, sfr_rdata})
    endtask
    task automatic xd_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) xd_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) xd_req <= '0;
    endtask
    task automatic xd_rd(input logic [15:0] a, input logic [8:0] e);
        @(posedge clk) xd_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) xd_req <= '0;
        #1 `CHK("xd read", e, {xd_hit, xd_rdata})
    endtask
    task automatic bank_chk(input logic f, m, e15, e16);
        @(posedge clk) {fetch, msb} <= {f, m};
        repeat (2) @(posedge clk);
        #1 `CHK("bank pins", {e15, 1'b1, e16}, {a15, pin_c.oe[7], pin_c.out[7]})
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // The limit is far above the roughly 115 cycles the sequence needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1 `CHK("pins idle", 24'h0, {pin_a.oe, pin_b.oe, pin_c.oe})
        `CHK("timers idle", 4'hf, {t0, t1, t2x, t2})
        sfr_rd(SFR_PORT_A_DATA, 1'b0, 9'h1ff);
        sfr_rd(SFR_PORT_A_DATA, 1'b1, 9'h100);
        sfr_rd(SFR_PORT_A_DIR, 1'b0, 9'h1ff);
        sfr_rd(SFR_PORT_B_DIR, 1'b0, 9'h1ff);
        xd_rd(XD_PORT_C_DATA, 9'h1ff);
        xd_rd(XD_PORT_C_DIR, 9'h1ff);
        xd_rd(XD_BANK_SEL, 9'h100);
        sfr_rd(8'h92, 1'b0, 9'h000);
        xd_rd(16'h0003, 9'h000);
        sfr_wr(SFR_PORT_A_DATA, 8'ha5);
        sfr_wr(SFR_PORT_A_DIR, 8'h0f);
        repeat (2) @(posedge clk);
        #1 `CHK("port a oe", 8'hf0, pin_a.oe)
        `CHK("timers", 4'h3, {t0, t1, t2x, t2})
        sfr_rd(SFR_PORT_A_DATA, 1'b0, 9'h1ac);
        sfr_rd(SFR_PORT_A_DATA, 1'b1, 9'h1a5);
        sfr_wr(SFR_PORT_B_DATA, 8'h55);
        sfr_rd(SFR_PORT_B_DATA, 1'b0, 9'h1ff);
        sfr_wr(SFR_PORT_B_DIR, 8'h00);
        sfr_rd(SFR_PORT_B_DATA, 1'b0, 9'h155);
        sfr_rd(SFR_PORT_B_DATA, 1'b1, 9'h155);
        xd_wr(XD_PORT_C_DATA, 8'h81);
        xd_wr(XD_PORT_C_DIR, 8'h7e);
        xd_rd(XD_PORT_C_DATA, 9'h1a5);
        xd_rd(XD_PORT_C_DIR, 9'h17e);
        xd_wr(XD_PORT_C_DIR, 8'hfe);
        for (int b = 0; b < 4; b++) begin
            xd_wr(XD_BANK_SEL, 8'ha4 | 8'(b));
            xd_rd(XD_BANK_SEL, {1'b1, 8'ha4 | 8'(b)});
            bank_chk(1'b1, 1'b1, ~b[0], b != 0);
            bank_chk(1'b1, 1'b0, 1'b0, 1'b0);
            bank_chk(1'b0, 1'b1, 1'b1, 1'b0);
        end
        xd_wr(XD_PORT_C_DIR, 8'h7e);
        xd_wr(XD_BANK_SEL, 8'h00);
        bank_chk(1'b1, 1'b1, 1'b1, 1'b1);
        print_verdict();
    end
endmodule
